// ### rtl/rlrc_top.sv
// record source select, handler returns and latch reporting
// Functional notes
// - each record array selects one data source
// - source list pairs with arrays by position
// - switch samples keep only bits 0-4
// - torque samples signed, clamped to +/-32767
// - next record index readable
// - error return resumes main program
// - error return arg keeps or drops wait
// - stack clear makes handler a jump
// - interrupt return resumes, re-enables input irqs
// - interrupt return arg keeps or drops wait
// - handlers entered only while program runs
// - report latest latched position per axis
// - armed latch captures on low input
// - input n triggers axis n latch
// - arm level selectable by configuration
`include "rlrc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module rlrc_top #(
	parameter int NAX = 4,
	parameter int W = 32,
	parameter int IDXW = 16
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// axis quantities, per axis W bits, torque 16 bits per axis, inputs and outputs W bits shared
	input wire logic [NAX*W-1:0] enc2_i,
	input wire logic [NAX*W-1:0] pos_i,
	input wire logic [NAX*W-1:0] perr_i,
	input wire logic [NAX*W-1:0] cpos_i,
	input wire logic [NAX*W-1:0] sw_i,
	input wire logic [NAX*W-1:0] stop_i,
	input wire logic [NAX*16-1:0] torque_i,
	input wire logic [W-1:0] inputs_i,
	input wire logic [W-1:0] outputs_i,
	// latch trigger inputs, one per axis
	input wire logic [NAX-1:0] latch_in_i,
	// handler events and record strobe
	input wire logic handler_label_a_evt_i,
	input wire logic limsw_evt_i,
	input wire logic inirq_evt_i,
	input wire logic rec_tick_i,
	// sequencer view
	output logic [1:0] seq_state_o,
	output logic wait_pending_o,
	output logic irq_en_o,
	output logic rec_valid_o,
	output logic irq_o
);
	import rlrc_pkg::*;

	logic rst_s1_q, rst_n_q;
	logic [31:0] ctrl_q;
	logic [NAX-1:0][3:0] rsel_q;
	logic [IDXW-1:0] ridx_q;
	logic [NAX-1:0][W-1:0] rdata_q;
	logic [2:0] irq_st_q, irq_msk_q, irq_set;
	rlrc_seq_e seq_q;
	logic ret_ok_q, wait_q, wait_sav_q, iien_q;
	logic [NAX-1:0][W-1:0] rpt_q, lpos;
	logic [NAX-1:0] armed, capt, arm_req;
	logic [31:0] rd_d;
	logic cmd_wr;
	logic [3:0] cmd_op;
	logic [NAX-1:0] cmd_axes;
	logic cmd_arg;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// command word: [3:0] op, [4] arg, [11:8] axis mask
	assign cmd_wr = wr_i && (addr_i == `RLRC_REG_CMD);
	assign cmd_op = wdata_i[3:0];
	assign cmd_arg = wdata_i[4];
	assign cmd_axes = wdata_i[8 +: NAX];

	always_ff @(posedge mclk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q <= 32'h0;
			rsel_q <= '0;
			irq_msk_q <= 3'h0;
		end else if (wr_i) begin
			case (addr_i)
				`RLRC_REG_CTRL: ctrl_q <= wdata_i;
				`RLRC_REG_RSEL: begin
					for (int a = 0; a < NAX; a++) begin
						rsel_q[a] <= wdata_i[4*a +: 4];
					end
				end
				`RLRC_REG_IRQMSK: irq_msk_q <= wdata_i[2:0];
				default: ;
			endcase
		end
	end

	// array n samples the quantity picked by nibble n
	function automatic logic [W-1:0] pick(input logic [3:0] s, input int a);
		logic [W-1:0] v;
		v = '0;
		case (rlrc_src_e'(s))
			RLRC_SRC_ENC2: v = enc2_i[a*W +: W];
			RLRC_SRC_POS: v = pos_i[a*W +: W];
			RLRC_SRC_PERR: v = perr_i[a*W +: W];
			RLRC_SRC_CPOS: v = cpos_i[a*W +: W];
			RLRC_SRC_LPOS: v = rpt_q[a];
			RLRC_SRC_INP: v = inputs_i;
			RLRC_SRC_OUTP: v = outputs_i;
			RLRC_SRC_SW: v = sw_i[a*W +: W] & W'(`RLRC_SW_MASK);
			RLRC_SRC_STOP: v = stop_i[a*W +: W];
			RLRC_SRC_TORQ: begin
				// -32768 has no meaning on the output scale, clamp it
				if ($signed(torque_i[a*16 +: 16]) < `RLRC_TORQUE_MIN) begin
					v = W'($signed(`RLRC_TORQUE_MIN));
				end else begin
					v = W'($signed(torque_i[a*16 +: 16]));
				end
			end
			default: v = '0;
		endcase
		return v;
	endfunction : pick

	always_ff @(posedge mclk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_q <= '0;
			ridx_q <= '0;
			rec_valid_o <= 1'b0;
		end else begin
			rec_valid_o <= 1'b0;
			if (wr_i && addr_i == `RLRC_REG_RIDX) begin
				ridx_q <= wdata_i[IDXW-1:0];
			end else if (ctrl_q[`RLRC_CTRL_REC] && rec_tick_i) begin
				for (int a = 0; a < NAX; a++) begin
					rdata_q[a] <= pick(rsel_q[a], a);
				end
				ridx_q <= ridx_q + 1'b1;
				rec_valid_o <= 1'b1;
			end
		end
	end

	// sequencer: main program, error handler, input irq handler
	always_ff @(posedge mclk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			seq_q <= RLRC_SEQ_IDLE;
			ret_ok_q <= 1'b1;
			wait_q <= 1'b0;
			wait_sav_q <= 1'b0;
			iien_q <= 1'b1;
		end else begin
			case (seq_q)
				RLRC_SEQ_IDLE: begin
					wait_q <= 1'b0;
					if (ctrl_q[`RLRC_CTRL_RUN]) begin
						seq_q <= RLRC_SEQ_MAIN;
						ret_ok_q <= 1'b1;
					end
				end
				RLRC_SEQ_MAIN: begin
					if (!ctrl_q[`RLRC_CTRL_RUN]) begin
						seq_q <= RLRC_SEQ_IDLE;
					end else if (handler_label_a_evt_i || limsw_evt_i) begin
						seq_q <= RLRC_SEQ_ERRH;
						wait_sav_q <= wait_q;
						wait_q <= 1'b0;
					end else if (inirq_evt_i && iien_q) begin
						seq_q <= RLRC_SEQ_IRQH;
						iien_q <= 1'b0;
						wait_sav_q <= wait_q;
						wait_q <= 1'b0;
					end else if (cmd_wr && cmd_op == 4'h0) begin
						wait_q <= cmd_arg;
					end
				end
				RLRC_SEQ_ERRH, RLRC_SEQ_IRQH: begin
					if (!ctrl_q[`RLRC_CTRL_RUN]) begin
						seq_q <= RLRC_SEQ_IDLE;
						iien_q <= 1'b1;
					end else if (cmd_wr && cmd_op == `RLRC_CMD_STACK_CLR) begin
						ret_ok_q <= 1'b0;
					end else if (cmd_wr && cmd_op == `RLRC_CMD_ERR_RET
							&& seq_q == RLRC_SEQ_ERRH) begin
						// with no return frame the handler just carries on
						if (ret_ok_q) begin
							seq_q <= RLRC_SEQ_MAIN;
							wait_q <= cmd_arg & wait_sav_q;
						end
					end else if (cmd_wr && cmd_op == `RLRC_CMD_IRQ_RET
							&& seq_q == RLRC_SEQ_IRQH) begin
						iien_q <= 1'b1;
						if (ret_ok_q) begin
							seq_q <= RLRC_SEQ_MAIN;
							wait_q <= cmd_arg & wait_sav_q;
						end
					end
				end
				default: seq_q <= RLRC_SEQ_IDLE;
			endcase
		end
	end

	always_comb begin
		for (int a = 0; a < NAX; a++) begin
			arm_req[a] = cmd_wr && cmd_op == `RLRC_CMD_LATCH_ARM && cmd_axes[a];
		end
	end

	for (genvar g = 0; g < NAX; g++) begin : g_latch
		rlrc_axis_latch #(
			.W(W)
		) u_latch (
			.clk_i(mclk_i),
			.rst_n_i(rst_n_q),
			.arm_i(arm_req[g]),
			.arm_level_i(ctrl_q[`RLRC_CTRL_ARMCFG]),
			.trig_i(latch_in_i[g]),
			.pos_i(pos_i[g*W +: W]),
			.armed_o(armed[g]),
			.capt_o(capt[g]),
			.pos_o(lpos[g])
		);
	end

	// report command copies the latched value for the chosen axes
	always_ff @(posedge mclk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rpt_q <= '0;
		end else if (cmd_wr && cmd_op == `RLRC_CMD_LATCH_RPT) begin
			for (int a = 0; a < NAX; a++) begin
				if (cmd_axes[a]) begin
					rpt_q[a] <= lpos[a];
				end
			end
		end
	end

	assign irq_set[`RLRC_IRQ_CAPT] = |capt;
	assign irq_set[`RLRC_IRQ_HND] = seq_q == RLRC_SEQ_MAIN && ctrl_q[`RLRC_CTRL_RUN]
		&& (handler_label_a_evt_i || limsw_evt_i || (inirq_evt_i && iien_q));
	assign irq_set[`RLRC_IRQ_RET] = cmd_wr && seq_q[1] && ret_ok_q
		&& (cmd_op == `RLRC_CMD_ERR_RET || cmd_op == `RLRC_CMD_IRQ_RET);

	// set beats a write-one clear in the same cycle
	always_ff @(posedge mclk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			irq_st_q <= 3'h0;
			irq_o <= 1'b0;
		end else begin
			if (wr_i && addr_i == `RLRC_REG_IRQST) begin
				irq_st_q <= (irq_st_q & ~wdata_i[2:0]) | irq_set;
			end else begin
				irq_st_q <= irq_st_q | irq_set;
			end
			irq_o <= |(irq_st_q & irq_msk_q);
		end
	end

	always_comb begin
		rd_d = 32'h0;
		case (addr_i)
			`RLRC_REG_CTRL: rd_d = ctrl_q;
			`RLRC_REG_RSEL: rd_d = 32'(rsel_q);
			`RLRC_REG_RIDX: rd_d = 32'(ridx_q);
			`RLRC_REG_LSTAT: rd_d = 32'(armed);
			`RLRC_REG_SEQ: rd_d = {27'h0, iien_q, ret_ok_q, wait_q, seq_q};
			`RLRC_REG_IRQST: rd_d = {29'h0, irq_st_q};
			`RLRC_REG_IRQMSK: rd_d = {29'h0, irq_msk_q};
			default: begin
				if (addr_i >= `RLRC_REG_LPOS0 && addr_i < `RLRC_REG_RDATA0) begin
					rd_d = 32'(rpt_q[addr_i[1:0]]);
				end else begin
					rd_d = 32'(rdata_q[addr_i[1:0]]);
				end
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_o <= 32'h0;
			seq_state_o <= 2'b00;
			wait_pending_o <= 1'b0;
			irq_en_o <= 1'b0;
		end else begin
			rdata_o <= rd_i ? rd_d : 32'h0;
			seq_state_o <= seq_q;
			wait_pending_o <= wait_q;
			irq_en_o <= iien_q;
		end
	end
endmodule : rlrc_top
`default_nettype wire

// ### rtl/rlrc_cfg.svh
// constants for the record/latch/return command block
`ifndef RLRC_CFG_SVH
`define RLRC_CFG_SVH
// register offsets (word index on the plain register port)
`define RLRC_REG_CTRL 4'h0
`define RLRC_REG_CMD 4'h1
`define RLRC_REG_RSEL 4'h2
`define RLRC_REG_RIDX 4'h3
`define RLRC_REG_LSTAT 4'h4
`define RLRC_REG_SEQ 4'h5
`define RLRC_REG_IRQST 4'h6
`define RLRC_REG_IRQMSK 4'h7
`define RLRC_REG_LPOS0 4'h8
`define RLRC_REG_RDATA0 4'hc
// command codes written to the command register
`define RLRC_CMD_ERR_RET 4'h1
`define RLRC_CMD_IRQ_RET 4'h2
`define RLRC_CMD_STACK_CLR 4'h3
`define RLRC_CMD_LATCH_ARM 4'h4
`define RLRC_CMD_LATCH_RPT 4'h5
// ctrl field positions
`define RLRC_CTRL_RUN 0
`define RLRC_CTRL_REC 1
`define RLRC_CTRL_ARMCFG 2
// irq status bits
`define RLRC_IRQ_CAPT 0
`define RLRC_IRQ_HND 1
`define RLRC_IRQ_RET 2
// switch bits that carry meaning, torque sample limits
`define RLRC_SW_MASK 32'h0000001f
`define RLRC_TORQUE_MAX 16'sh7fff
`define RLRC_TORQUE_MIN 16'sh8001
`endif

// ### rtl/rlrc_pkg.sv
// types for the record/latch/return command block
package rlrc_pkg;
	typedef enum logic [3:0] {
		RLRC_SRC_ENC2 = 4'h0,
		RLRC_SRC_POS = 4'h1,
		RLRC_SRC_PERR = 4'h2,
		RLRC_SRC_CPOS = 4'h3,
		RLRC_SRC_LPOS = 4'h4,
		RLRC_SRC_INP = 4'h5,
		RLRC_SRC_OUTP = 4'h6,
		RLRC_SRC_SW = 4'h7,
		RLRC_SRC_STOP = 4'h8,
		RLRC_SRC_TORQ = 4'h9
	} rlrc_src_e;
	typedef enum logic [1:0] {
		RLRC_SEQ_IDLE = 2'b00,
		RLRC_SEQ_MAIN = 2'b01,
		RLRC_SEQ_ERRH = 2'b10,
		RLRC_SEQ_IRQH = 2'b11
	} rlrc_seq_e;
endpackage : rlrc_pkg

// ### rtl/rlrc_axis_latch.sv
// one axis position latch: armed, trigger input at the arm level captures position
`timescale 1ns/10ps
`default_nettype none
module rlrc_axis_latch #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// control
	input wire logic arm_i,
	input wire logic arm_level_i,
	// axis side
	input wire logic trig_i,
	input wire logic [W-1:0] pos_i,
	// result
	output logic armed_o,
	output logic capt_o,
	output logic [W-1:0] pos_o
);
	logic hit;

	// trigger is active low unless configured to the opposite level
	assign hit = armed_o && (trig_i == arm_level_i);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			armed_o <= 1'b0;
			pos_o <= '0;
			capt_o <= 1'b0;
		end else begin
			capt_o <= hit;
			if (hit) begin
				pos_o <= pos_i;
				armed_o <= 1'b0;
			end else if (arm_i) begin
				armed_o <= 1'b1;
			end
		end
	end
endmodule : rlrc_axis_latch
`default_nettype wire

// ### bench/rlrc_top_sva.sv
// port assertions for the record, latch and return block
`include "rlrc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module rlrc_top_sva (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	// events and sequencer view
	input wire logic handler_label_a_evt_i,
	input wire logic limsw_evt_i,
	input wire logic inirq_evt_i,
	input wire logic [1:0] seq_state_o,
	input wire logic wait_pending_o,
	input wire logic irq_en_o,
	input wire logic irq_o
);
	import rlrc_pkg::*;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	logic err_req;
	assign err_req = handler_label_a_evt_i || limsw_evt_i;
	sequence s_cmd(op);
		wr_i && addr_i == `RLRC_REG_CMD && wdata_i[3:0] == op;
	endsequence
	// a later mask write would hide the effect
	sequence s_mask_off;
		wr_i && addr_i == `RLRC_REG_IRQMSK && wdata_i == 32'h0 ##1 !wr_i;
	endsequence
	chk_rdata_idle:
		assert property (!$past(rd_i) |-> rdata_o == 32'h0) else $error("stray read data");
	chk_hnd_from_main:
		assert property ($changed(seq_state_o) && seq_state_o[1] |->
			$past(seq_state_o) == RLRC_SEQ_MAIN) else $error("handler not from main");
	chk_idle_exit:
		assert property (seq_state_o == RLRC_SEQ_IDLE |=>
			seq_state_o inside {RLRC_SEQ_IDLE, RLRC_SEQ_MAIN}) else $error("idle left badly");
	// state outputs are a registered copy, so effects show two edges on
	chk_err_entry:
		assert property (seq_state_o == RLRC_SEQ_MAIN && err_req && !wr_i |-> ##2
			seq_state_o == RLRC_SEQ_ERRH) else $error("error handler missed");
	chk_irq_entry:
		assert property (seq_state_o == RLRC_SEQ_MAIN && inirq_evt_i && irq_en_o && !err_req
			&& !wr_i |-> ##2 seq_state_o == RLRC_SEQ_IRQH && !irq_en_o) else $error("irq entry");
	chk_irq_reen:
		assert property (seq_state_o == RLRC_SEQ_IRQH ##0 s_cmd(`RLRC_CMD_IRQ_RET) |-> ##2
			irq_en_o) else $error("irq not enabled again");
	chk_err_drop:
		assert property (seq_state_o == RLRC_SEQ_ERRH ##0 s_cmd(`RLRC_CMD_ERR_RET) ##0
			!wdata_i[4] |-> ##2 !wait_pending_o) else $error("error return kept wait");
	chk_irq_drop:
		assert property (seq_state_o == RLRC_SEQ_IRQH ##0 s_cmd(`RLRC_CMD_IRQ_RET) ##0
			!wdata_i[4] |-> ##2 !wait_pending_o) else $error("irq return kept wait");
	chk_mask_off:
		assert property (s_mask_off |=> !irq_o) else $error("masked irq still high");
endmodule : rlrc_top_sva
`default_nettype wire

// ### bench/rlrc_axis_model.sv
// far-side model: axis positions and active-low latch inputs
`timescale 1ns/10ps
`default_nettype none
module rlrc_axis_model (
	// clock
	input wire logic clk_i,
	// trigger requests, one per axis
	input wire logic [3:0] trig_i,
	// axis side
	output logic [127:0] pos_o,
	output logic [3:0] latch_n_o
);
	logic [1:0] hold_q [4];
	initial begin
		pos_o = {32'h4000, 32'h3000, 32'h2000, 32'h1000};
		hold_q = '{default: 2'h0};
	end
	always @(posedge clk_i) begin
		for (int a = 0; a < 4; a++) begin
			if (trig_i[a]) begin
				hold_q[a] <= 2'h3;
			end else if (hold_q[a] != 2'h0) begin
				hold_q[a] <= hold_q[a] - 2'h1;
				// position moves only once the pulse is over
				if (hold_q[a] == 2'h1) begin
					pos_o[a*32+:32] <= pos_o[a*32+:32] + 32'h11;
				end
			end
		end
	end
	always_comb begin
		for (int a = 0; a < 4; a++) begin
			latch_n_o[a] = hold_q[a] == 2'h0;
		end
	end
endmodule : rlrc_axis_model
`default_nettype wire

// ### bench/tb_rlrc_top.sv
// self-checking bench for the record, latch and return block
`include "rlrc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_rlrc_top;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] evt = 8'h0;
	logic [3:0] k = 4'h0;
	logic [127:0] enc2, perr, cpos, sw, stop, pos;
	logic [63:0] trq = 64'h0001_fffe_7fff_8000;
	logic [31:0] rdata_o, inp, outp;
	logic [31:0] lat [4];
	logic [3:0] latch_n;
	logic [1:0] seq_state_o;
	logic wait_pending_o, irq_en_o, rec_valid_o, irq_o, rv;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	always #50 mclk_i = ~mclk_i;
	function automatic logic [31:0] qv(logic [3:0] q, logic [3:0] a);
		return {q, k, a, 20'h5a5f3};
	endfunction : qv
	always_comb begin
		inp = qv(4'h5, 4'h0);
		outp = qv(4'h6, 4'h0);
		for (int a = 0; a < 4; a++) begin
			enc2[a*32+:32] = qv(4'h0, 4'(a));
			perr[a*32+:32] = qv(4'h2, 4'(a));
			cpos[a*32+:32] = qv(4'h3, 4'(a));
			sw[a*32+:32] = qv(4'h7, 4'(a));
			stop[a*32+:32] = qv(4'h8, 4'(a));
		end
	end
	function automatic logic [31:0] ex(int s, int a);
		logic [15:0] t;
		t = trq[a*16+:16];
		case (s)
			1: return pos[a*32+:32];
			4: return lat[a];
			5: return inp;
			6: return outp;
			7: return qv(4'h7, 4'(a)) & 32'h1f;
			9: return t == 16'h8000 ? 32'hffff8001 : {{16{t[15]}}, t};
			default: return qv(4'(s), 4'(a));
		endcase
	endfunction : ex
	rlrc_top rlrc_top_i (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.enc2_i(enc2), .pos_i(pos), .perr_i(perr), .cpos_i(cpos), .sw_i(sw), .stop_i(stop),
		.torque_i(trq), .inputs_i(inp), .outputs_i(outp), .latch_in_i(latch_n),
		.handler_label_a_evt_i(evt[0]), .limsw_evt_i(evt[1]), .inirq_evt_i(evt[2]), .rec_tick_i(evt[3]),
		.seq_state_o, .wait_pending_o, .irq_en_o, .rec_valid_o, .irq_o);
	rlrc_axis_model rlrc_axis_model_i (.clk_i(mclk_i), .trig_i(evt[7:4]), .pos_o(pos),
		.latch_n_o(latch_n));
	always @(posedge mclk_i) begin
		if (rec_valid_o) rv <= 1'b1;
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	task automatic chk(logic [31:0] g, logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(logic [3:0] a, logic [31:0] e);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, e);
	endtask : rd
	task automatic cmd(logic [3:0] op, logic arg, logic [3:0] m);
		wr(`RLRC_REG_CMD, {20'h0, m, 3'h0, arg, op});
	endtask : cmd
	task automatic ev(logic [7:0] v);
		@(posedge mclk_i);
		evt <= v;
		@(posedge mclk_i);
		evt <= 8'h0;
	endtask : ev
	// e and m: {irq, irq enable, wait, state}
	task automatic st(logic [4:0] e, logic [4:0] m);
		repeat (3) @(posedge mclk_i);
		#1;
		chk({27'h0, {irq_o, irq_en_o, wait_pending_o, seq_state_o} & m}, {27'h0, e});
	endtask : st
	initial begin
		repeat (4) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		cmd(`RLRC_CMD_LATCH_ARM, 1'b0, 4'hf);
		lat[1] = pos[63:32];
		ev(8'h20);
		repeat (5) @(posedge mclk_i);
		rd(`RLRC_REG_LSTAT, 32'hd);
		cmd(`RLRC_CMD_LATCH_RPT, 1'b0, 4'hf);
		rd(4'h9, lat[1]);
		rd(4'h8, 32'h0);
		ev(8'h20);
		repeat (5) @(posedge mclk_i);
		cmd(`RLRC_CMD_LATCH_RPT, 1'b0, 4'h2);
		rd(4'h9, lat[1]);
		lat[0] = pos[31:0];
		lat[2] = pos[95:64];
		lat[3] = pos[127:96];
		wr(`RLRC_REG_CTRL, 32'h4);
		cmd(`RLRC_CMD_LATCH_ARM, 1'b0, 4'h4);
		rd(`RLRC_REG_LSTAT, 32'h0);
		cmd(`RLRC_CMD_LATCH_RPT, 1'b0, 4'hf);
		for (int a = 0; a < 4; a++) rd(4'h8 + 4'(a), lat[a]);
		$display("test latch done");
		wr(`RLRC_REG_RIDX, 32'h5);
		wr(`RLRC_REG_CTRL, 32'h2);
		for (int s = 0; s < 10; s++) begin
			k = 4'(s);
			wr(`RLRC_REG_RSEL, {16'h0, 4'((s+3)%10), 4'((s+2)%10), 4'((s+1)%10), 4'(s)});
			rv = 1'b0;
			ev(8'h08);
			repeat (3) @(posedge mclk_i);
			chk({31'h0, rv}, 32'h1);
			for (int a = 0; a < 4; a++) rd(`RLRC_REG_RDATA0 + 4'(a), ex((s+a)%10, a));
		end
		rd(`RLRC_REG_RIDX, 32'hf);
		$display("test record done");
		wr(`RLRC_REG_IRQST, 32'h7);
		ev(8'h01);
		st(5'h00, 5'h03);
		wr(`RLRC_REG_SEQ, 32'h10);
		wr(`RLRC_REG_CTRL, 32'h1);
		wr(`RLRC_REG_IRQMSK, 32'h7);
		cmd(4'h0, 1'b1, 4'h0);
		st(5'h0d, 5'h0f);
		ev(8'h01);
		st(5'h12, 5'h13);
		cmd(`RLRC_CMD_ERR_RET, 1'b1, 4'h0);
		st(5'h0d, 5'h0f);
		ev(8'h01);
		cmd(`RLRC_CMD_ERR_RET, 1'b0, 4'h0);
		st(5'h09, 5'h0f);
		ev(8'h02);
		cmd(`RLRC_CMD_ERR_RET, 1'b0, 4'h0);
		st(5'h09, 5'h0f);
		rd(`RLRC_REG_IRQST, 32'h6);
		wr(`RLRC_REG_IRQST, 32'h6);
		st(5'h00, 5'h10);
		cmd(4'h0, 1'b1, 4'h0);
		ev(8'h04);
		st(5'h03, 5'h0f);
		cmd(`RLRC_CMD_IRQ_RET, 1'b1, 4'h0);
		st(5'h0d, 5'h0f);
		ev(8'h04);
		cmd(`RLRC_CMD_IRQ_RET, 1'b0, 4'h0);
		st(5'h09, 5'h0f);
		ev(8'h04);
		cmd(`RLRC_CMD_STACK_CLR, 1'b0, 4'h0);
		cmd(`RLRC_CMD_IRQ_RET, 1'b0, 4'h0);
		st(5'h1b, 5'h1f);
		wr(`RLRC_REG_IRQMSK, 32'h0);
		st(5'h00, 5'h10);
		$display("test sequencer done");
		final_report();
	end
endmodule : tb_rlrc_top
bind rlrc_top rlrc_top_sva rlrc_top_sva_i (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
	.rd_i, .rdata_o, .handler_label_a_evt_i, .limsw_evt_i, .inirq_evt_i, .seq_state_o,
	.wait_pending_o, .irq_en_o, .irq_o);
`default_nettype wire
